// ---- core/ifb_flag_bank.sv ----
// Purpose: interrupt enable and request-flag bank behind an APB slave
// Assumes: event inputs are one-cycle pulses on sys_clk; pins asynchronous
// Notes: set wins over a software clear in the same cycle
// Functional notes
// RL1 - pin b edge: 00 off, 01 rise, 10 fall
// RL2 - pin a edge field in bits 1-0
// RL3 - code 11 triggers on both edges
// RL4 - edge register upper six bits read zero; the code keeps only bits 7-4 zero, bits 3-2 hold the pin b field
// RL5 - group 0 flag at ctrl0 bit 6
// RL6 - comparator flag at ctrl0 bit 5
// RL7 - pin a flag at ctrl0 bit 4
// RL8 - group 0 enable at ctrl0 bit 3
// RL9 - comparator enable at ctrl0 bit 2
// RL10 - pin a enable at ctrl0 bit 1
// RL11 - global enable at ctrl0 bit 0
// RL12 - group 1 enable at ctrl1 bit 0
// RL13 - no converter: omit its enable, flag
// RL14 - pin b flag at ctrl2 bit 5
// RL15 - time base b flag at ctrl2 bit 4
// RL16 - pin b, time base b enables bits 1, 0
// RL17 - timer0 match A flag at bit 5
// RL18 - timer0 match P flag at bit 4
// RL19 - timer0 match A/P enables bits 1, 0
// RL20 - all bits reset zero, software read/write
// RL21 - request needs own and global enable
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "ifb_defs.svh"
module ifb_flag_bank #(
  parameter bit HAS_CONVERTER = 1'b1
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extPinA,
  input wire logic extPinB,
  input wire logic comparatorEvent,
  input wire logic timebaseAEvent,
  input wire logic timebaseBEvent,
  input wire logic converterEvent,
  input wire logic group1Event,
  input wire logic group2Event,
  input wire logic timer0MatchAEvent,
  input wire logic timer0MatchPEvent,
  output logic irqRequest
);
  logic rstSync1_reg, rstSync2_reg;
  logic [7:0] edgeSel_reg, ctrl0_reg, ctrl1_reg, ctrl2_reg, tmr0_reg;
  logic [7:0] ctrl1Mask;
  logic [1:0] pinASync_reg, pinBSync_reg;
  logic pinAOld_reg, pinBOld_reg;
  logic pinAHit, pinBHit;
  logic [31:0] prdata_reg;
  logic wrEn, rdEn, addrOk;
  logic [7:0] wrByte;
  logic serviceWr;
  logic [7:0] pending;
  logic group0Pending;

  // reset released through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end

  // pin synchronisers, first stage read only by second
  always_ff @(posedge sys_clk or negedge rstSync2_reg) begin
    if (!rstSync2_reg) begin
      pinASync_reg <= 2'b00;
      pinBSync_reg <= 2'b00;
      pinAOld_reg <= 1'b0;
      pinBOld_reg <= 1'b0;
    end else begin
      pinASync_reg <= {pinASync_reg[0], extPinA};
      pinBSync_reg <= {pinBSync_reg[0], extPinB};
      pinAOld_reg <= pinASync_reg[1];
      pinBOld_reg <= pinBSync_reg[1];
    end
  end

  function automatic logic edgeHit(input logic [1:0] sel, input logic now,
                                   input logic old);
    logic rise, fall;
    rise = now & ~old;
    fall = ~now & old;
    // RL1 edge code decode
    case (ifb_pkg::ifb_edge_type'(sel))
      ifb_pkg::IFB_EDGE_OFF: edgeHit = 1'b0;
      ifb_pkg::IFB_EDGE_RISE: edgeHit = rise;
      ifb_pkg::IFB_EDGE_FALL: edgeHit = fall;
      // RL3 both edges
      ifb_pkg::IFB_EDGE_BOTH: edgeHit = rise | fall;
      default: edgeHit = 1'b0;
    endcase
  endfunction

  // RL2 pin a field low bits
  assign pinAHit = edgeHit(edgeSel_reg[1:0], pinASync_reg[1], pinAOld_reg);
  assign pinBHit = edgeHit(edgeSel_reg[3:2], pinBSync_reg[1], pinBOld_reg);

  // apb decode, zero wait states
  assign pready = 1'b1;
  assign addrOk = (paddr == `IFB_OFF_EDGE) || (paddr == `IFB_OFF_CTRL0) ||
                  (paddr == `IFB_OFF_CTRL1) || (paddr == `IFB_OFF_CTRL2) ||
                  (paddr == `IFB_OFF_TMR0) || (paddr == `IFB_OFF_SERVICE) ||
                  (paddr == `IFB_OFF_STATUS);
  assign pslverr = psel & penable & ~addrOk;
  assign wrEn = psel & penable & pwrite & addrOk;
  assign rdEn = psel & ~penable & ~pwrite;
  assign wrByte = pwdata[7:0];
  assign serviceWr = wrEn && (paddr == `IFB_OFF_SERVICE) && wrByte[0];
  // RL13 converter bits absent without converter
  assign ctrl1Mask = HAS_CONVERTER ? 8'hFF : `IFB_CTRL1_NOCONV_MASK;

  // RL20 edge register reset and write
  always_ff @(posedge sys_clk or negedge rstSync2_reg) begin
    if (!rstSync2_reg) begin
      edgeSel_reg <= `IFB_RST_VAL;
    end else if (wrEn && paddr == `IFB_OFF_EDGE) begin
      // RL4 upper bits stay zero
      edgeSel_reg <= wrByte & `IFB_EDGE_MASK;
    end
  end

  // group 0 is the timer0 match pair, its flag is set by the enabled sub-requests
  assign group0Pending =
    (tmr0_reg[`IFB_POS_T0A_FLAG] & tmr0_reg[`IFB_POS_T0A_EN]) |
    (tmr0_reg[`IFB_POS_T0P_FLAG] & tmr0_reg[`IFB_POS_T0P_EN]);

  always_ff @(posedge sys_clk or negedge rstSync2_reg) begin
    if (!rstSync2_reg) begin
      ctrl0_reg <= `IFB_RST_VAL;
    end else begin
      // RL8 RL9 RL10 RL11 enables writable
      if (wrEn && paddr == `IFB_OFF_CTRL0) begin
        ctrl0_reg <= wrByte & `IFB_CTRL0_MASK;
      end
      // RL21 servicing drops global enable
      if (serviceWr) begin
        ctrl0_reg[`IFB_POS_GLOBAL_EN] <= 1'b0;
      end
      // RL7 pin a flag set wins
      if (pinAHit) begin
        ctrl0_reg[`IFB_POS_PIN_A_FLAG] <= 1'b1;
      end
      // RL6 comparator flag set
      if (comparatorEvent) begin
        ctrl0_reg[`IFB_POS_CMP_FLAG] <= 1'b1;
      end
      // RL5 group 0 flag set
      if (group0Pending) begin
        ctrl0_reg[`IFB_POS_GRP0_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync2_reg) begin
    if (!rstSync2_reg) begin
      ctrl1_reg <= `IFB_RST_VAL;
    end else begin
      // RL12 group 1 enable writable
      if (wrEn && paddr == `IFB_OFF_CTRL1) begin
        ctrl1_reg <= wrByte & ctrl1Mask;
      end
      if (timebaseAEvent) begin
        ctrl1_reg[`IFB_POS_TBA_FLAG] <= 1'b1;
      end
      if (converterEvent && HAS_CONVERTER) begin
        ctrl1_reg[`IFB_POS_CONV_FLAG] <= 1'b1;
      end
      if (group2Event) begin
        ctrl1_reg[`IFB_POS_GRP2_FLAG] <= 1'b1;
      end
      if (group1Event) begin
        ctrl1_reg[`IFB_POS_GRP1_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync2_reg) begin
    if (!rstSync2_reg) begin
      ctrl2_reg <= `IFB_RST_VAL;
    end else begin
      // RL16 pin b and time base b enables
      if (wrEn && paddr == `IFB_OFF_CTRL2) begin
        ctrl2_reg <= wrByte & `IFB_CTRL2_MASK;
      end
      // RL14 pin b flag set
      if (pinBHit) begin
        ctrl2_reg[`IFB_POS_PIN_B_FLAG] <= 1'b1;
      end
      // RL15 time base b flag set
      if (timebaseBEvent) begin
        ctrl2_reg[`IFB_POS_TBB_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstSync2_reg) begin
    if (!rstSync2_reg) begin
      tmr0_reg <= `IFB_RST_VAL;
    end else begin
      // RL19 timer0 match enables
      if (wrEn && paddr == `IFB_OFF_TMR0) begin
        tmr0_reg <= wrByte & `IFB_TMR0_MASK;
      end
      // RL17 match A flag set
      if (timer0MatchAEvent) begin
        tmr0_reg[`IFB_POS_T0A_FLAG] <= 1'b1;
      end
      // RL18 match P flag set
      if (timer0MatchPEvent) begin
        tmr0_reg[`IFB_POS_T0P_FLAG] <= 1'b1;
      end
    end
  end

  // RL21 flag gated by own enable
  assign pending[0] = ctrl0_reg[`IFB_POS_PIN_A_FLAG] &
                      ctrl0_reg[`IFB_POS_PIN_A_EN];
  assign pending[1] = ctrl0_reg[`IFB_POS_CMP_FLAG] &
                      ctrl0_reg[`IFB_POS_CMP_EN];
  assign pending[2] = ctrl0_reg[`IFB_POS_GRP0_FLAG] &
                      ctrl0_reg[`IFB_POS_GRP0_EN];
  assign pending[3] = ctrl1_reg[`IFB_POS_TBA_FLAG] &
                      ctrl1_reg[`IFB_POS_TBA_EN];
  assign pending[4] = ctrl1_reg[`IFB_POS_CONV_FLAG] &
                      ctrl1_reg[`IFB_POS_CONV_EN];
  assign pending[5] = (ctrl1_reg[`IFB_POS_GRP1_FLAG] &
                       ctrl1_reg[`IFB_POS_GRP1_EN]) |
                      (ctrl1_reg[`IFB_POS_GRP2_FLAG] &
                       ctrl1_reg[`IFB_POS_GRP2_EN]);
  assign pending[6] = ctrl2_reg[`IFB_POS_PIN_B_FLAG] &
                      ctrl2_reg[`IFB_POS_PIN_B_EN];
  assign pending[7] = ctrl2_reg[`IFB_POS_TBB_FLAG] &
                      ctrl2_reg[`IFB_POS_TBB_EN];

  // RL21 global gate on request
  always_ff @(posedge sys_clk or negedge rstSync2_reg) begin
    if (!rstSync2_reg) begin
      irqRequest <= 1'b0;
    end else begin
      irqRequest <= ctrl0_reg[`IFB_POS_GLOBAL_EN] & (|pending);
    end
  end

  // read data captured in setup phase
  always_ff @(posedge sys_clk or negedge rstSync2_reg) begin
    if (!rstSync2_reg) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rdEn) begin
      case (paddr)
        `IFB_OFF_EDGE: prdata_reg <= {24'h00_0000, edgeSel_reg};
        `IFB_OFF_CTRL0: prdata_reg <= {24'h00_0000, ctrl0_reg};
        `IFB_OFF_CTRL1: prdata_reg <= {24'h00_0000, ctrl1_reg};
        `IFB_OFF_CTRL2: prdata_reg <= {24'h00_0000, ctrl2_reg};
        `IFB_OFF_TMR0: prdata_reg <= {24'h00_0000, tmr0_reg};
        `IFB_OFF_STATUS: prdata_reg <= {24'h00_0000, pending};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_reg;

  // edge field upper bits read zero
  upper_zero_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    edgeSel_reg[7:4] == 4'h0) else $error("edge upper bits set"); // RL4
  rise_sets_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    (edgeSel_reg[1:0] == 2'b01 && pinASync_reg[1] && !pinAOld_reg)
    |=> ctrl0_reg[`IFB_POS_PIN_A_FLAG]) else $error("rise lost"); // RL1
  both_edges_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    (edgeSel_reg[3:2] == 2'b11 && pinBSync_reg[1] != pinBOld_reg)
    |=> ctrl2_reg[`IFB_POS_PIN_B_FLAG]) else $error("edge lost"); // RL3
  off_no_flag_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    (edgeSel_reg[1:0] == 2'b00 && !(wrEn && paddr == `IFB_OFF_CTRL0)
     && !ctrl0_reg[`IFB_POS_PIN_A_FLAG])
    |=> !ctrl0_reg[`IFB_POS_PIN_A_FLAG]) else $error("disabled pin set"); // RL2
  cmp_set_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    comparatorEvent |=> ctrl0_reg[`IFB_POS_CMP_FLAG])
    else $error("cmp flag lost"); // RL6
  tbb_set_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    timebaseBEvent |=> ctrl2_reg[`IFB_POS_TBB_FLAG])
    else $error("tbb flag lost"); // RL15
  match_set_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    timer0MatchAEvent |=> tmr0_reg[`IFB_POS_T0A_FLAG] ##1
    ctrl0_reg[`IFB_POS_GRP0_FLAG] || !tmr0_reg[`IFB_POS_T0A_EN])
    else $error("match flag lost"); // RL17
  global_gate_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    irqRequest |-> $past(ctrl0_reg[`IFB_POS_GLOBAL_EN]))
    else $error("request without global"); // RL21
  service_clr_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    serviceWr |=> !ctrl0_reg[`IFB_POS_GLOBAL_EN])
    else $error("global not cleared"); // RL11
  conv_absent_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    !HAS_CONVERTER |-> ctrl1_reg[`IFB_POS_CONV_FLAG] == 1'b0)
    else $error("converter bit present"); // RL13

  // pin a falling edge seen with the fall code selected
  sequence pinAFall_s;
    edgeSel_reg[1:0] == 2'b10 && !pinASync_reg[1] && pinAOld_reg;
  endsequence

  // pin b rising edge seen with the rise code selected
  sequence pinBRise_s;
    edgeSel_reg[3:2] == 2'b01 && pinBSync_reg[1] && !pinBOld_reg;
  endsequence

  // match a flag and its enable both standing
  sequence matchAArmed_s;
    tmr0_reg[`IFB_POS_T0A_FLAG] && tmr0_reg[`IFB_POS_T0A_EN];
  endsequence

  // an enabled source with the global enable set
  sequence anyEnabled_s;
    ctrl0_reg[`IFB_POS_GLOBAL_EN] && (|pending);
  endsequence

  fall_sets_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    pinAFall_s |=> ctrl0_reg[`IFB_POS_PIN_A_FLAG])
    else $error("fall lost"); // RL1
  pinb_rise_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    pinBRise_s |=> ctrl2_reg[`IFB_POS_PIN_B_FLAG])
    else $error("pin b flag lost"); // RL14
  match_p_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    timer0MatchPEvent |=> tmr0_reg[`IFB_POS_T0P_FLAG])
    else $error("match p flag lost"); // RL18
  grp0_follow_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    matchAArmed_s |=> ctrl0_reg[`IFB_POS_GRP0_FLAG])
    else $error("group 0 flag lost"); // RL5
  irq_raise_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    anyEnabled_s |=> irqRequest)
    else $error("request not raised"); // RL21
  irq_source_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    irqRequest |-> $past(|pending))
    else $error("request without source"); // RL21
  ctrl2_gaps_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    ctrl2_reg[7:6] == 2'b00 && ctrl2_reg[3:2] == 2'b00)
    else $error("ctrl2 gap bits set"); // RL16
  tmr0_gaps_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    tmr0_reg[7:6] == 2'b00 && tmr0_reg[3:2] == 2'b00)
    else $error("timer0 gap bits set"); // RL19
  ctrl0_top_a: assert property (@(posedge sys_clk) disable iff (!rstSync2_reg)
    ctrl0_reg[7] == 1'b0)
    else $error("ctrl0 bit 7 set"); // RL8
endmodule // ifb_flag_bank

// ---- core/ifb_defs.svh ----
// Purpose: offsets, field positions and reset values of the flag bank
// Assumes: one aligned 32-bit word per register
// Notes: none
`ifndef IFB_DEFS_SVH
`define IFB_DEFS_SVH
`define IFB_OFF_EDGE 12'h000
`define IFB_OFF_CTRL0 12'h004
`define IFB_OFF_CTRL1 12'h008
`define IFB_OFF_CTRL2 12'h00C
`define IFB_OFF_TMR0 12'h010
`define IFB_OFF_SERVICE 12'h014
`define IFB_OFF_STATUS 12'h018
`define IFB_RST_VAL 8'h00
`define IFB_EDGE_MASK 8'h0F
`define IFB_CTRL0_MASK 8'h7F
`define IFB_CTRL2_MASK 8'h33
`define IFB_TMR0_MASK 8'h33
`define IFB_CTRL1_NOCONV_MASK 8'hBB
`define IFB_POS_GLOBAL_EN 0
`define IFB_POS_PIN_A_EN 1
`define IFB_POS_CMP_EN 2
`define IFB_POS_GRP0_EN 3
`define IFB_POS_PIN_A_FLAG 4
`define IFB_POS_CMP_FLAG 5
`define IFB_POS_GRP0_FLAG 6
`define IFB_POS_GRP1_EN 0
`define IFB_POS_GRP2_EN 1
`define IFB_POS_CONV_EN 2
`define IFB_POS_TBA_EN 3
`define IFB_POS_GRP1_FLAG 4
`define IFB_POS_GRP2_FLAG 5
`define IFB_POS_CONV_FLAG 6
`define IFB_POS_TBA_FLAG 7
`define IFB_POS_TBB_EN 0
`define IFB_POS_PIN_B_EN 1
`define IFB_POS_TBB_FLAG 4
`define IFB_POS_PIN_B_FLAG 5
`define IFB_POS_T0P_EN 0
`define IFB_POS_T0A_EN 1
`define IFB_POS_T0P_FLAG 4
`define IFB_POS_T0A_FLAG 5
`endif

// ---- core/ifb_pkg.sv ----
// Purpose: types of the flag bank
// Assumes: nothing
// Notes: edge codes of the two-bit select fields
package ifb_pkg;
  typedef enum logic [1:0] {
    IFB_EDGE_OFF = 2'b00,
    IFB_EDGE_RISE = 2'b01,
    IFB_EDGE_FALL = 2'b10,
    IFB_EDGE_BOTH = 2'b11
  } ifb_edge_type;
endpackage

// ---- tb/tb.sv ----
// Purpose: register-level bench for the interrupt flag bank
// Assumes: zero-wait APB slave, converter present, pulse event inputs
// Notes: flags are cleared by software writes between checks
`timescale 1ns/100ps
`include "ifb_defs.svh"
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin nMismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  logic sysClk;
  logic resetN;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic extPinA;
  logic extPinB;
  logic [7:0] ev;
  logic irqRequest;
  logic [31:0] rdData;
  logic rdErr;
  int nMismatch;
  int checksDone;
  logic [11:0] regAddr [5] = '{`IFB_OFF_EDGE, `IFB_OFF_CTRL0,
    `IFB_OFF_CTRL1, `IFB_OFF_CTRL2, `IFB_OFF_TMR0};
  logic [7:0] regMask [5] = '{`IFB_EDGE_MASK, `IFB_CTRL0_MASK, 8'hFF,
    `IFB_CTRL2_MASK, `IFB_TMR0_MASK};
  // event order: cmp, tbA, tbB, conv, grp1, grp2, t0A, t0P
  logic [11:0] evAddr [8] = '{`IFB_OFF_CTRL0, `IFB_OFF_CTRL1,
    `IFB_OFF_CTRL2, `IFB_OFF_CTRL1, `IFB_OFF_CTRL1, `IFB_OFF_CTRL1,
    `IFB_OFF_TMR0, `IFB_OFF_TMR0};
  logic [7:0] evBit [8] = '{8'h20, 8'h80, 8'h10, 8'h40, 8'h10, 8'h20,
    8'h20, 8'h10};

  ifb_flag_bank ifb_flag_bank_i (
    .sys_clk(sysClk), .reset_n(resetN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extPinA(extPinA),
    .extPinB(extPinB), .comparatorEvent(ev[0]), .timebaseAEvent(ev[1]),
    .timebaseBEvent(ev[2]), .converterEvent(ev[3]), .group1Event(ev[4]),
    .group2Event(ev[5]), .timer0MatchAEvent(ev[6]),
    .timer0MatchPEvent(ev[7]), .irqRequest(irqRequest)
  );

  initial begin
    sysClk = 1'h0;
    forever #5 sysClk = ~sysClk;
  end

  task automatic summarize();
    if (nMismatch == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic apbXfer(input logic wr, input logic [11:0] a,
                         input logic [7:0] d);
    @(posedge sysClk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sysClk);
    penable <= 1'h1;
    do begin
      @(posedge sysClk);
    end while (pready !== 1'h1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic chkRead(input logic [11:0] a, input logic [7:0] e);
    apbXfer(1'h0, a, 8'h00);
    `CHK(rdData, {24'h000000, e})
    `CHK(rdErr, 1'h0)
  endtask

  task automatic irqChk(input logic e);
    repeat (2) @(posedge sysClk);
    #1;
    `CHK(irqRequest, e)
  endtask

  initial begin
    #100000;
    nMismatch++;
    summarize();
  end

  initial begin
    logic [1:0] cA;
    logic [1:0] cB;
    resetN = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    extPinA = 1'h0;
    extPinB = 1'h0;
    ev = 8'h00;
    nMismatch = 0;
    checksDone = 0;
    repeat (2) @(posedge sysClk);
    resetN <= 1'h1;
    repeat (3) @(posedge sysClk);
    for (int i = 0; i < 5; i++) chkRead(regAddr[i], 8'h00);
    for (int i = 0; i < 5; i++) begin
      apbXfer(1'h1, regAddr[i], 8'hFF);
      chkRead(regAddr[i], regMask[i]);
    end
    irqChk(1'h1);
    for (int i = 4; i >= 0; i--) begin
      apbXfer(1'h1, regAddr[i], 8'h00);
      chkRead(regAddr[i], 8'h00);
    end
    irqChk(1'h0);
    apbXfer(1'h1, `IFB_OFF_TMR0, 8'h22);
    chkRead(`IFB_OFF_CTRL0, 8'h40);
    apbXfer(1'h1, `IFB_OFF_TMR0, 8'h00);
    apbXfer(1'h1, `IFB_OFF_CTRL0, 8'h00);
    apbXfer(1'h0, 12'h01C, 8'h00);
    `CHK(rdErr, 1'h1)
    `CHK(rdData, 32'h00000000)
    for (int i = 0; i < 8; i++) begin
      @(posedge sysClk);
      ev <= 8'h01 << i;
      @(posedge sysClk);
      ev <= 8'h00;
      chkRead(evAddr[i], evBit[i]);
      apbXfer(1'h1, evAddr[i], 8'h00);
    end
    for (int c = 0; c < 4; c++) begin
      cA = c[1:0];
      cB = ~cA;
      apbXfer(1'h1, `IFB_OFF_EDGE, {4'h0, cB, cA});
      apbXfer(1'h1, `IFB_OFF_CTRL0, 8'h00);
      apbXfer(1'h1, `IFB_OFF_CTRL2, 8'h00);
      @(posedge sysClk);
      extPinA <= 1'h1;
      extPinB <= 1'h1;
      repeat (6) @(posedge sysClk);
      chkRead(`IFB_OFF_CTRL0, cA[0] ? 8'h10 : 8'h00);
      chkRead(`IFB_OFF_CTRL2, cB[0] ? 8'h20 : 8'h00);
      apbXfer(1'h1, `IFB_OFF_CTRL0, 8'h00);
      apbXfer(1'h1, `IFB_OFF_CTRL2, 8'h00);
      @(posedge sysClk);
      extPinA <= 1'h0;
      extPinB <= 1'h0;
      repeat (6) @(posedge sysClk);
      chkRead(`IFB_OFF_CTRL0, cA[1] ? 8'h10 : 8'h00);
      chkRead(`IFB_OFF_CTRL2, cB[1] ? 8'h20 : 8'h00);
    end
    apbXfer(1'h1, `IFB_OFF_EDGE, 8'h00);
    apbXfer(1'h1, `IFB_OFF_CTRL2, 8'h00);
    apbXfer(1'h1, `IFB_OFF_CTRL0, 8'h24);
    irqChk(1'h0);
    apbXfer(1'h1, `IFB_OFF_CTRL0, 8'h25);
    irqChk(1'h1);
    chkRead(`IFB_OFF_STATUS, 8'h02);
    apbXfer(1'h1, `IFB_OFF_SERVICE, 8'h01);
    chkRead(`IFB_OFF_CTRL0, 8'h24);
    irqChk(1'h0);
    summarize();
  end
endmodule // tb
